// [design/ec_ctrl.v]
// Control register bank of the dual echo canceller
// Overview of operation
// - Main bit 0 reloads every register default.
// - Soft reset bit self-clears when init done.
// - Main bit 1 disables howling detection.
// - Main bit 2 disables automatic gain control.
// - Main bit 3 disables both narrowband detectors.
// - Main bit 4 bypasses send and receive paths.
// - Main bit 5 mutes send output, quiet code.
// - Main bit 6 mutes receive output, quiet code.
// - Main bit 7 gates the shift mode.
// - Canceller bit 0 stops estimate subtraction.
// - Canceller bit 1 freezes filter adaptation.
// - Canceller bit 2 clears filter coefficients.
// - Acoustic bit 3 bypasses send offset nulling.
// - Line bit 3 bypasses receive offset nulling.
// - Canceller bit 4 disables noise fill.
// - Acoustic bit 5 disables send nonlinear processor.
// - Line bit 5 disables receive nonlinear processor.
// - Canceller bit 6 disables adaptation speed control.
// - Acoustic bit 7 disables exponential weighting.
// - Shift mode scales inputs right, outputs left.
// - Shift ignored unless both ports linear.
// - Shift ignored when main bit 7 clear.
`include "ec_ctrl_regs.vh"
module ec_ctrl #(
	parameter INIT_CYCLES = `INIT_CYCLES
) (
	input  wire        i_mclk,
	input  wire        i_nrst,
	input  wire        i_wr,
	input  wire        i_rd,
	input  wire [7:0]  i_addr,
	input  wire [7:0]  i_wdata,
	output reg  [7:0]  o_rdata,
	output reg         o_rvalid,
	input  wire [1:0]  i_send_format,
	input  wire [1:0]  i_recv_format,
	output reg         o_howl_detect_disable,
	output reg         o_auto_gain_disable,
	output reg         o_narrowband_detect_disable,
	output reg         o_path_bypass,
	output reg         o_send_mute,
	output reg         o_recv_mute,
	output reg  [15:0] o_send_quiet,
	output reg  [15:0] o_recv_quiet,
	output reg         o_two_bit_scaling,
	output reg  [1:0]  o_estimate_subtract_bypass,
	output reg  [1:0]  o_filter_update_freeze,
	output reg  [1:0]  o_coefficient_clear,
	output reg  [1:0]  o_offset_null_bypass,
	output reg  [1:0]  o_noise_fill_disable,
	output reg  [1:0]  o_nonlinear_proc_disable,
	output reg  [1:0]  o_step_speed_ctrl_disable,
	output reg         o_weighting_disable,
	output reg         o_init_busy
);
	// ------------------------------------------------------------
	// Registers and init sequencer
	// ------------------------------------------------------------
	localparam ST_IDLE = 2'b01;
	localparam ST_INIT = 2'b10;

	reg  [7:0]  main_control;
	reg  [7:0]  line_canceller_control;
	reg  [7:0]  acoustic_canceller_control;
	reg  [1:0]  state;
	reg  [15:0] init_count;
	wire [15:0] send_quiet;
	wire [15:0] recv_quiet;
	wire        both_linear;

	assign both_linear = (i_send_format == `FMT_LINEAR) &&
		(i_recv_format == `FMT_LINEAR);

	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			main_control <= `RST_MAIN_CONTROL;
			line_canceller_control <= `RST_LINE_CONTROL;
			acoustic_canceller_control <= `RST_ACOUSTIC_CONTROL;
			state <= ST_IDLE;
			init_count <= 16'h0000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (i_wr && i_addr == `ADDR_MAIN_CONTROL &&
						i_wdata[`MAIN_SOFT_RESET]) begin
						main_control <= `RST_MAIN_CONTROL | 8'h01;
						line_canceller_control <= `RST_LINE_CONTROL;
						acoustic_canceller_control <=
							`RST_ACOUSTIC_CONTROL;
						init_count <= 16'h0000;
						state <= ST_INIT;
					end else if (i_wr) begin
						case (i_addr)
							`ADDR_MAIN_CONTROL:
								main_control <= i_wdata;
							`ADDR_LINE_CONTROL:
								line_canceller_control <= i_wdata;
							`ADDR_ACOUSTIC_CONTROL:
								acoustic_canceller_control <= i_wdata;
							default: ;
						endcase
					end
				end
				ST_INIT: begin
					if (init_count == INIT_CYCLES[15:0] - 16'h0001) begin
						main_control[`MAIN_SOFT_RESET] <= 1'b0;
						state <= ST_IDLE;
					end else begin
						init_count <= init_count + 16'h0001;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
			case (i_addr)
				`ADDR_MAIN_CONTROL:     o_rdata <= main_control;
				`ADDR_LINE_CONTROL:     o_rdata <= line_canceller_control;
				`ADDR_ACOUSTIC_CONTROL: o_rdata <= acoustic_canceller_control;
				default:                o_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Quiet codes
	// ------------------------------------------------------------
	quiet_code u_send_quiet (
		.i_format (i_send_format),
		.o_quiet  (send_quiet)
	);
	quiet_code u_recv_quiet (
		.i_format (i_recv_format),
		.o_quiet  (recv_quiet)
	);

	// ------------------------------------------------------------
	// Control outputs, index 0 acoustic, index 1 line
	// ------------------------------------------------------------
	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_howl_detect_disable <= 1'b0;
			o_auto_gain_disable <= 1'b0;
			o_narrowband_detect_disable <= 1'b0;
			o_path_bypass <= 1'b0;
			o_send_mute <= 1'b0;
			o_recv_mute <= 1'b0;
			o_send_quiet <= 16'h0000;
			o_recv_quiet <= 16'h0000;
			o_two_bit_scaling <= 1'b0;
			o_estimate_subtract_bypass <= 2'h0;
			o_filter_update_freeze <= 2'h0;
			o_coefficient_clear <= 2'h0;
			o_offset_null_bypass <= 2'h0;
			o_noise_fill_disable <= 2'h0;
			o_nonlinear_proc_disable <= 2'h0;
			o_step_speed_ctrl_disable <= 2'h0;
			o_weighting_disable <= 1'b0;
			o_init_busy <= 1'b0;
		end else begin
			o_howl_detect_disable <= main_control[`MAIN_HOWL_DIS];
			o_auto_gain_disable <= main_control[`MAIN_GAIN_DIS];
			o_narrowband_detect_disable <=
				main_control[`MAIN_NARROW_DIS];
			o_path_bypass <= main_control[`MAIN_BYPASS];
			o_send_mute <= main_control[`MAIN_MUTE_SEND];
			o_recv_mute <= main_control[`MAIN_MUTE_RECV];
			o_send_quiet <= send_quiet;
			o_recv_quiet <= recv_quiet;
			o_two_bit_scaling <= main_control[`MAIN_SHIFT_GATE] &&
				line_canceller_control[`CC_BIT7] &&
				both_linear;
			o_estimate_subtract_bypass <= {
				line_canceller_control[`CC_SUB_BYPASS],
				acoustic_canceller_control[`CC_SUB_BYPASS]};
			o_filter_update_freeze <= {
				line_canceller_control[`CC_FREEZE],
				acoustic_canceller_control[`CC_FREEZE]};
			o_coefficient_clear <= {
				line_canceller_control[`CC_COEF_CLEAR],
				acoustic_canceller_control[`CC_COEF_CLEAR]};
			o_offset_null_bypass <= {
				line_canceller_control[`CC_OFFSET_BYPASS],
				acoustic_canceller_control[`CC_OFFSET_BYPASS]};
			o_noise_fill_disable <= {
				line_canceller_control[`CC_NOISE_DIS],
				acoustic_canceller_control[`CC_NOISE_DIS]};
			o_nonlinear_proc_disable <= {
				line_canceller_control[`CC_NONLIN_DIS],
				acoustic_canceller_control[`CC_NONLIN_DIS]};
			o_step_speed_ctrl_disable <= {
				line_canceller_control[`CC_SPEED_DIS],
				acoustic_canceller_control[`CC_SPEED_DIS]};
			o_weighting_disable <= acoustic_canceller_control[`CC_BIT7];
			o_init_busy <= (state == ST_INIT);
		end
	end
endmodule

// [design/ec_ctrl_regs.vh]
// Register offsets, field positions, reset values and timing counts
`ifndef EC_CTRL_REGS_VH
`define EC_CTRL_REGS_VH
`define ADDR_MAIN_CONTROL      8'h00
`define ADDR_LINE_CONTROL      8'h01
`define ADDR_ACOUSTIC_CONTROL  8'h21
`define RST_MAIN_CONTROL       8'h00
`define RST_LINE_CONTROL       8'h00
`define RST_ACOUSTIC_CONTROL   8'h00
`define MAIN_SOFT_RESET        0
`define MAIN_HOWL_DIS          1
`define MAIN_GAIN_DIS          2
`define MAIN_NARROW_DIS        3
`define MAIN_BYPASS            4
`define MAIN_MUTE_SEND         5
`define MAIN_MUTE_RECV         6
`define MAIN_SHIFT_GATE        7
`define CC_SUB_BYPASS          0
`define CC_FREEZE              1
`define CC_COEF_CLEAR          2
`define CC_OFFSET_BYPASS       3
`define CC_NOISE_DIS           4
`define CC_NONLIN_DIS          5
`define CC_SPEED_DIS           6
`define CC_BIT7                7
`define INIT_CYCLES            16
`define FMT_ULAW               2'h0
`define FMT_ALAW               2'h1
`define FMT_LINEAR             2'h2
`define QUIET_ULAW             8'hFF
`define QUIET_ALAW             8'hD5
`endif

// [design/quiet_code.v]
// Silence code chooser for one PCM port
`include "ec_ctrl_regs.vh"
module quiet_code (
	input  wire [1:0]  i_format,
	output reg  [15:0] o_quiet
);
	always @* begin
		case (i_format)
			`FMT_ULAW: o_quiet = {8'h00, `QUIET_ULAW};
			`FMT_ALAW: o_quiet = {8'h00, `QUIET_ALAW};
			default:   o_quiet = 16'h0000;
		endcase
	end
endmodule

// [sim/ec_ctrl_props.sv]
// Assertion checker bound to the control register bank
module ec_ctrl_props #(parameter INIT_CYCLES = 16) (
	input logic        i_mclk, i_nrst, i_wr, o_howl_detect_disable,
	input logic        o_auto_gain_disable, o_send_mute, o_init_busy,
	input logic        o_two_bit_scaling,
	input logic [7:0]  i_addr, i_wdata,
	input logic [1:0]  i_send_format, i_recv_format,
	input logic [15:0] o_send_quiet
);
	timeunit 1ns;
	timeprecision 1ns;
	int  bc;
	wire wm = i_wr && i_addr == 8'h00 && !i_wdata[0] && !o_init_busy;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	always @(posedge i_mclk)
		bc <= (!i_nrst || !o_init_busy) ? 0 : bc + 1;
	howl_level_a: assert property (wm |-> ##2
		o_howl_detect_disable == $past(i_wdata[1], 2)) else $error("howl");
	gain_level_a: assert property (wm |-> ##2
		o_auto_gain_disable == $past(i_wdata[2], 2)) else $error("gain");
	send_mute_a: assert property (wm |-> ##2
		o_send_mute == $past(i_wdata[5], 2)) else $error("send mute");
	scale_gate_a: assert property (wm && !i_wdata[7] |-> ##2
		!o_two_bit_scaling) else $error("scaling not gated");
	scale_format_a: assert property (o_two_bit_scaling |->
		$past(i_send_format) == 2'h2 && $past(i_recv_format) == 2'h2)
		else $error("scaling without linear");
	quiet_ulaw_a: assert property (i_send_format == 2'h0 |=>
		o_send_quiet == 16'h00FF) else $error("quiet code");
	busy_length_a: assert property ($fell(o_init_busy) |->
		bc == INIT_CYCLES) else $error("init length");
	init_clear_a: assert property ($rose(o_init_busy) |->
		!o_howl_detect_disable && !o_send_mute) else $error("init clear");
endmodule
bind ec_ctrl ec_ctrl_props #(.INIT_CYCLES(INIT_CYCLES)) ec_ctrl_props_i (
	.i_mclk, .i_nrst, .i_wr, .i_addr, .i_wdata, .i_send_format,
	.i_recv_format, .o_howl_detect_disable, .o_auto_gain_disable,
	.o_send_mute, .o_two_bit_scaling, .o_init_busy, .o_send_quiet);

// [sim/host_model.sv]
// Host side of the microport, one access at a time
module host_model (
	input  logic       i_mclk,
	output logic       o_wr = 1'b0,
	output logic       o_rd = 1'b0,
	output logic [7:0] o_addr = 8'h00,
	output logic [7:0] o_wdata = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	task automatic access(input logic w, input logic [7:0] a, d);
		@(posedge i_mclk);
		o_wr <= w;
		o_rd <= !w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_mclk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
endmodule

// [sim/test_ec_ctrl.sv]
// Self-checking bench for the control register bank
module test_ec_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_mclk = 1'b0, i_nrst = 1'b0, i_wr, i_rd, o_rvalid, o_init_busy;
	logic o_howl_detect_disable, o_auto_gain_disable, o_path_bypass;
	logic o_narrowband_detect_disable, o_send_mute, o_recv_mute;
	logic o_two_bit_scaling, o_weighting_disable;
	logic [7:0] i_addr, i_wdata, o_rdata, exp_q[$];
	logic [15:0] o_send_quiet, o_recv_quiet;
	logic [1:0] i_send_format = 2'h0, i_recv_format = 2'h0;
	logic [1:0] o_estimate_subtract_bypass, o_filter_update_freeze;
	logic [1:0] o_coefficient_clear, o_offset_null_bypass;
	logic [1:0] o_noise_fill_disable, o_nonlinear_proc_disable;
	logic [1:0] o_step_speed_ctrl_disable;
	logic [7:0] adr[3] = '{8'h00, 8'h01, 8'h21};
	logic [7:0] msk[3] = '{8'h7E, 8'h7F, 8'hFF};
	int fail_count = 0, samples_checked = 0;
	ec_ctrl #(.INIT_CYCLES(6)) ec_ctrl_i (.i_mclk, .i_nrst, .i_wr, .i_rd,
		.i_addr, .i_wdata, .o_rdata, .o_rvalid, .i_send_format,
		.i_recv_format, .o_howl_detect_disable, .o_auto_gain_disable,
		.o_narrowband_detect_disable, .o_path_bypass, .o_send_mute,
		.o_recv_mute, .o_send_quiet, .o_recv_quiet, .o_two_bit_scaling,
		.o_estimate_subtract_bypass, .o_filter_update_freeze,
		.o_coefficient_clear, .o_offset_null_bypass, .o_noise_fill_disable,
		.o_nonlinear_proc_disable, .o_step_speed_ctrl_disable,
		.o_weighting_disable, .o_init_busy);
	host_model host_model_i (.i_mclk, .o_wr(i_wr), .o_rd(i_rd),
		.o_addr(i_addr), .o_wdata(i_wdata));
	initial forever #10 i_mclk = ~i_mclk;
	task chk(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task summarize;
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task rd(input logic [7:0] a, e);
		exp_q.push_back(e);
		host_model_i.access(1'b0, a, 8'h00);
	endtask
	function automatic logic [15:0] qc(input logic [1:0] f);
		qc = f == 2'h0 ? 16'h00FF : f == 2'h1 ? 16'h00D5 : 16'h0000;
	endfunction
	function automatic logic [15:0] seen(input int k);
		int j;
		j = k == 1;
		if (k == 0)
			seen = {9'h000, o_recv_mute, o_send_mute, o_path_bypass,
				o_narrowband_detect_disable, o_auto_gain_disable,
				o_howl_detect_disable, 1'b0};
		else
			seen = {8'h00, k == 2 && o_weighting_disable,
				o_step_speed_ctrl_disable[j], o_nonlinear_proc_disable[j],
				o_noise_fill_disable[j], o_offset_null_bypass[j],
				o_coefficient_clear[j], o_filter_update_freeze[j],
				o_estimate_subtract_bypass[j]};
	endfunction
	always @(posedge i_mclk)
		if (o_rvalid === 1'b1)
			chk({8'h00, o_rdata}, {8'h00, exp_q.pop_front()});
	initial begin
		logic [7:0] d;
		void'($urandom(81));
		repeat (3) @(posedge i_mclk);
		i_nrst <= 1'b1;
		for (int k = 0; k < 4; k++)
			rd(k < 3 ? adr[k] : 8'h05, 8'h00);
		for (int n = 0; n < 12; n++) begin
			d = $urandom & (n % 3 == 0 ? 8'hFE : 8'hFF);
			host_model_i.access(1'b1, adr[n % 3], d);
			@(posedge i_mclk);
			#1 chk(seen(n % 3), {8'h00, d & msk[n % 3]});
			rd(adr[n % 3], d);
		end
		host_model_i.access(1'b1, 8'h00, 8'h80);
		host_model_i.access(1'b1, 8'h01, 8'h80);
		for (int i = 0; i < 16; i++) begin
			@(posedge i_mclk);
			i_send_format <= i[1:0];
			i_recv_format <= i[3:2];
			repeat (3) @(posedge i_mclk);
			#1 chk(o_send_quiet, qc(i[1:0]));
			chk(o_recv_quiet, qc(i[3:2]));
			chk({15'h0000, o_two_bit_scaling}, {15'h0000, i == 10});
		end
		@(posedge i_mclk);
		i_send_format <= 2'h2;
		i_recv_format <= 2'h2;
		repeat (2) @(posedge i_mclk);
		#1 chk({15'h0000, o_two_bit_scaling}, 16'h0001);
		host_model_i.access(1'b1, 8'h00, 8'h00);
		@(posedge i_mclk);
		#1 chk({15'h0000, o_two_bit_scaling}, 16'h0000);
		host_model_i.access(1'b1, 8'h21, 8'hFF);
		host_model_i.access(1'b1, 8'h00, 8'hFE);
		host_model_i.access(1'b1, 8'h00, 8'h7F);
		rd(8'h00, 8'h01);
		host_model_i.access(1'b1, 8'h21, 8'h5A);
		for (int t = 0; o_init_busy !== 1'b0; t++) begin
			if (t == 50) begin
				fail_count++;
				summarize();
			end
			@(posedge i_mclk);
		end
		for (int k = 0; k < 3; k++)
			rd(adr[k], 8'h00);
		#1 chk(seen(2), 16'h0000);
		chk(seen(0), 16'h0000);
		chk({15'h0000, o_two_bit_scaling}, 16'h0000);
		repeat (3) @(posedge i_mclk);
		summarize();
	end
endmodule
